// *** byte_slave_port.sv ***
// byte slave port with apb registers and interrupt
// Operation
// - 8-bit parallel slave port on data pins
// - port enabled by mode bit, together with the conditions below
// - disabled while dual or quad pwm
// - pin0 read, pin1 write, pin2 select
// - strobe direction bits must be inputs
// - converter config must hold 1010
// - external party accesses single byte latch
// - write spans select and write low
// - write end sets input full, irq flag
// - read start drives latch, sets output full
// - software write during read skips flag
// - read end releases pins, sets irq flag
// - software polls flags after irq flag
`timescale 1ns/100ps
module byte_slave_port
   import byte_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [byte_port_pkg::addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] data_pins_in,
   output logic [7:0] data_pins_out,
   output logic [7:0] data_pins_oe,
   input wire logic strobe_pin_zero_n,
   input wire logic strobe_pin_one_n,
   input wire logic strobe_pin_two_n,
   output logic irq
);
   import byte_port_pkg::*;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] direction;
      logic [2:0] strobe_dir;
      logic mode;
      logic [3:0] converter;
      logic pwm_multi;
      logic in_full;
      logic out_full;
      logic in_overflow;
      logic [2:0] flags;
      logic [2:0] mask;
      logic [7:0] in_byte;
      logic writing;
      logic reading;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0] pins_out;
      logic [7:0] pins_oe;
      logic irq;
   } port_state_type;

   port_state_type state, next_state;
   logic [2:0] strobes;
   logic [7:0] pins_sync1, pins_sync2;

   strobe_sync #(.width(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({strobe_pin_two_n, strobe_pin_one_n, strobe_pin_zero_n}),
      .sync_out(strobes)
   );

   // data pins used in a write, settled by then, and read as the pins register while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_sync1 <= 8'h00;
         pins_sync2 <= 8'h00;
      end else begin
         pins_sync1 <= data_pins_in;
         pins_sync2 <= pins_sync1;
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   logic slave_active;
   logic wr_low, rd_low;
   logic apb_access;
   logic write_end, read_start, read_end, overflow_event;
   logic pins_write;
   logic [2:0] flag_events;
   always_comb begin
      // select gates both strobes; pin mux needs inputs and digital pins
      slave_active = state.mode && !state.pwm_multi
         && state.strobe_dir == reset_strobe_dir
         && state.converter == digital_pins_code;
      wr_low = slave_active && !strobes[2] && !strobes[1];
      rd_low = slave_active && !strobes[2] && !strobes[0];
      apb_access = psel && penable && !state.ready;
      // an access ends even when the port is disabled under it
      write_end = state.writing && !wr_low;
      read_start = !state.reading && rd_low;
      read_end = state.reading && !rd_low;
      overflow_event = write_end && state.in_full;
      flag_events = 3'h0;
      flag_events[bit_flag_write] = write_end;
      flag_events[bit_flag_read] = read_end;
      flag_events[bit_flag_ovf] = overflow_event;
      pins_write = apb_access && pwrite && (hit(paddr, off_pins) || hit(paddr, off_latch));
   end

   always_comb begin
      next_state = state;
      next_state.ready = 1'b0;
      next_state.err = 1'b0;
      next_state.writing = wr_low;
      next_state.reading = rd_low;
      if (wr_low) begin
         next_state.in_byte = pins_sync2;
      end
      if (write_end) begin
         // a software write in the same cycle overrides this byte
         next_state.latch = state.in_byte;
      end
      if (apb_access) begin
         next_state.ready = 1'b1;
         next_state.rdata = 32'h0000_0000;
         if (hit(paddr, off_pins)) begin
            next_state.rdata = {24'h000000, slave_active ? state.latch : pins_sync2};
            if (!pwrite) begin
               next_state.in_full = 1'b0; // reading the port consumes input
            end
         end else if (hit(paddr, off_latch)) begin
            next_state.rdata = {24'h000000, state.latch};
         end else if (hit(paddr, off_direction)) begin
            next_state.rdata = {24'h000000, state.direction};
         end else if (hit(paddr, off_strobe_dir)) begin
            next_state.rdata = {24'h000000, state.in_full, state.out_full, state.in_overflow,
               state.mode,
               1'b0, state.strobe_dir};
         end else if (hit(paddr, off_flags)) begin
            next_state.rdata = {29'h0, state.flags};
            if (!pwrite) begin
               // read clears; events are merged in afterwards
               next_state.flags = 3'h0;
            end
         end else if (hit(paddr, off_enables)) begin
            next_state.rdata = {29'h0, state.mask};
         end else if (hit(paddr, off_converter)) begin
            next_state.rdata = {28'h0, state.converter};
         end else if (hit(paddr, off_pwm_mode)) begin
            next_state.rdata = {31'h0, state.pwm_multi};
         end else begin
            next_state.err = 1'b1;
         end
         if (pwrite) begin
            if (hit(paddr, off_pins) || hit(paddr, off_latch)) begin
               next_state.latch = pwdata[7:0];
               // during an external read the byte goes out with no flag
               if (!rd_low) begin
                  next_state.out_full = 1'b1;
               end
            end else if (hit(paddr, off_direction)) begin
               next_state.direction = pwdata[7:0];
            end else if (hit(paddr, off_strobe_dir)) begin
               next_state.mode = pwdata[bit_mode];
               next_state.strobe_dir = pwdata[2:0];
               next_state.in_overflow = state.in_overflow && pwdata[bit_in_overflow];
            end else if (hit(paddr, off_enables)) begin
               next_state.mask = pwdata[2:0];
            end else if (hit(paddr, off_converter)) begin
               next_state.converter = pwdata[3:0];
            end else if (hit(paddr, off_pwm_mode)) begin
               next_state.pwm_multi = pwdata[0];
            end
         end
      end
      // sets come after the software clears, so a same-cycle event wins
      if (write_end) begin
         next_state.in_full = 1'b1;
      end
      if (overflow_event) begin
         next_state.in_overflow = 1'b1;
      end
      if (read_start) begin
         next_state.out_full = 1'b1;
      end
      // a byte written just as the read ends is still waiting
      if (read_end && !pins_write) begin
         next_state.out_full = 1'b0;
      end
      next_state.flags = next_state.flags | flag_events;
      if (rd_low) begin
         next_state.pins_out = next_state.latch;
         next_state.pins_oe = 8'hFF;
      end else if (slave_active) begin
         next_state.pins_out = next_state.latch;
         next_state.pins_oe = 8'h00;
      end else begin
         next_state.pins_out = next_state.latch;
         next_state.pins_oe = ~next_state.direction;
      end
      next_state.irq = |(next_state.flags & next_state.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
         state.direction <= reset_direction;
         state.strobe_dir <= reset_strobe_dir;
         state.converter <= reset_converter;
      end else begin
         state <= next_state;
      end
   end

   assign prdata = state.rdata;
   assign pready = state.ready;
   assign pslverr = state.err;
   assign data_pins_out = state.pins_out;
   assign data_pins_oe = state.pins_oe;
   assign irq = state.irq;

   sequence s_write_end;
      state.writing ##1 !state.writing;
   endsequence

   sequence s_read_start;
      !state.reading ##1 state.reading;
   endsequence

   sequence s_read_end;
      state.reading ##1 !state.reading;
   endsequence

   // external write
   a_write_sets_full: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_end |-> state.in_full && state.flags[bit_flag_write])
      else $error("write end did not set input full and flag");

   a_write_irq: assert property (@(posedge pclk) disable iff (!presetn)
      write_end && state.mask[bit_flag_write] |=> irq)
      else $error("write end raised no interrupt");

   a_latch_takes_byte: assert property (@(posedge pclk) disable iff (!presetn)
      write_end && !pins_write |=> state.latch == $past(state.in_byte))
      else $error("written byte not latched");

   a_in_byte_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_low |=> $stable(state.in_byte))
      else $error("captured byte changed outside a write");

   a_ovf_on_full: assert property (@(posedge pclk) disable iff (!presetn)
      overflow_event |=> state.in_overflow)
      else $error("overflow not set");

   a_ovf_needs_event: assert property (@(posedge pclk) disable iff (!presetn)
      !state.in_overflow && !overflow_event |=> !state.in_overflow)
      else $error("overflow set with no event");

   a_once_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_end |=> !write_end)
      else $error("write flagged twice");

   // external read and pin output enables
   a_read_sets_out: assert property (@(posedge pclk) disable iff (!presetn)
      s_read_start |-> state.out_full)
      else $error("read start did not set output full");

   a_read_drives: assert property (@(posedge pclk) disable iff (!presetn)
      rd_low |=> data_pins_oe == 8'hFF)
      else $error("read not driving pins");

   a_read_drives_latch: assert property (@(posedge pclk) disable iff (!presetn)
      rd_low |=> data_pins_out == state.latch)
      else $error("read drives a byte other than the latch");

   a_late_byte_out: assert property (@(posedge pclk) disable iff (!presetn)
      pins_write && rd_low |=> data_pins_out == $past(pwdata[7:0]))
      else $error("byte written during read not driven");

   a_read_end_flag: assert property (@(posedge pclk) disable iff (!presetn)
      state.reading && !rd_low |=> state.flags[bit_flag_read] && data_pins_oe == 8'h00
         || !slave_active)
      else $error("read end not flagged");

   a_read_clears_out: assert property (@(posedge pclk) disable iff (!presetn)
      s_read_end |-> !state.out_full || $past(pins_write))
      else $error("output full kept after read end");

   a_read_irq: assert property (@(posedge pclk) disable iff (!presetn)
      read_end && state.mask[bit_flag_read] |=> irq)
      else $error("read end raised no interrupt");

   a_port_idle_oe: assert property (@(posedge pclk) disable iff (!presetn)
      slave_active && !rd_low |=> data_pins_oe == 8'h00)
      else $error("idle slave port drives pins");

   a_gpio_oe: assert property (@(posedge pclk) disable iff (!presetn)
      !slave_active |=> data_pins_oe == ~state.direction)
      else $error("general port enables do not follow direction");

   // enable conditions
   a_gate_pwm: assert property (@(posedge pclk) disable iff (!presetn)
      state.pwm_multi |-> !wr_low && !rd_low)
      else $error("port active during pwm");

   a_gate_config: assert property (@(posedge pclk) disable iff (!presetn)
      state.converter != digital_pins_code |-> !slave_active)
      else $error("port active without digital pins");

   a_gate_dir: assert property (@(posedge pclk) disable iff (!presetn)
      state.strobe_dir != reset_strobe_dir |-> !slave_active)
      else $error("port active with output strobes");

   a_mode_needed: assert property (@(posedge pclk) disable iff (!presetn)
      !state.mode |-> !slave_active)
      else $error("port active without mode");

   a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !slave_active |=> !state.writing && !state.reading)
      else $error("access seen on a disabled port");

   // status and interrupt
   a_pins_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      apb_access && !pwrite && hit(paddr, off_pins) && !write_end |=> !state.in_full)
      else $error("port read left input full set");

   a_flags_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
      apb_access && !pwrite && hit(paddr, off_flags) && flag_events == 3'h0
         |=> state.flags == 3'h0)
      else $error("flag read did not clear");

   a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
      |(state.flags & state.mask) |-> irq)
      else $error("irq missing");

   a_mask_gates_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (state.flags & state.mask) == 3'h0 |-> !irq)
      else $error("irq without an unmasked flag");

   // register bus
   a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error response without ready");
endmodule // byte_slave_port

// *** byte_port_pkg.sv ***
// constants shared by the byte slave port
package byte_port_pkg;
   localparam int addr_width = 8;
   localparam logic [7:0] off_pins = 8'h00;
   localparam logic [7:0] off_latch = 8'h04;
   localparam logic [7:0] off_direction = 8'h08;
   localparam logic [7:0] off_strobe_dir = 8'h0C;
   localparam logic [7:0] off_flags = 8'h10;
   localparam logic [7:0] off_enables = 8'h14;
   localparam logic [7:0] off_converter = 8'h18;
   localparam logic [7:0] off_pwm_mode = 8'h1C;
   localparam int bit_in_full = 7;
   localparam int bit_out_full = 6;
   localparam int bit_in_overflow = 5;
   localparam int bit_mode = 4;
   localparam int bit_flag_write = 0;
   localparam int bit_flag_read = 1;
   localparam int bit_flag_ovf = 2;
   localparam logic [3:0] digital_pins_code = 4'hA;
   localparam logic [7:0] reset_direction = 8'hFF;
   localparam logic [2:0] reset_strobe_dir = 3'h7;
   localparam logic [3:0] reset_converter = 4'h0;
   localparam int sync_stages = 2;
endpackage

// *** strobe_sync.sv ***
// two-stage synchroniser for the strobe pins
`timescale 1ns/100ps
module strobe_sync #(
   parameter int width = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] first;
      logic [width-1:0] second;
   } sync_state_type;
   sync_state_type state, next_state;
   always_comb begin
      next_state.first = async_in;
      next_state.second = state.first;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{first: '1, second: '1};
      end else begin
         state <= next_state;
      end
   end
   assign sync_out = state.second;
endmodule // strobe_sync

// *** ext_cpu_model.sv ***
// external processor that drives the byte port strobes and data
`timescale 1ns/100ps
module ext_cpu_model (
   input wire logic pclk,
   input wire logic [7:0] data_pins_out,
   input wire logic [7:0] data_pins_oe,
   output logic [7:0] data_pins_in,
   output logic rd_n,
   output logic wr_n,
   output logic cs_n
);
   logic [7:0] drv = 8'h00;
   // released bits hold a written byte until two cycles after the strobes, then show the inverse of the last byte
   assign data_pins_in = (data_pins_oe & data_pins_out) | (~data_pins_oe & drv);
   initial begin
      rd_n = 1'b1;
      wr_n = 1'b1;
      cs_n = 1'b1;
   end
   task automatic write_byte(input logic [7:0] b, input int hold);
      @(posedge pclk);
      drv <= b;
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (hold) @(posedge pclk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      // data outlives the strobes by the same sync depth
      repeat (2) @(posedge pclk);
      drv <= ~b;
   endtask
   task automatic read_begin();
      @(posedge pclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
   endtask
   task automatic read_end(input int hold, output logic [7:0] q);
      repeat (hold) @(posedge pclk);
      q = data_pins_in;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      drv <= ~q;
   endtask
endmodule // ext_cpu_model

// *** tb_byte_slave_port.sv ***
// self-checking bench for the byte slave port and its registers
`timescale 1ns/100ps
module tb_byte_slave_port;
   import byte_port_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, irq, err, rd_n, wr_n, cs_n;
   logic [7:0] pins_in, pins_out, pins_oe, q;
   logic [31:0] cfg_dir [4] = '{32'h07, 32'h17, 32'h16, 32'h17};
   logic [31:0] cfg_conv [4] = '{32'h0A, 32'h0A, 32'h0A, 32'h00};
   logic [31:0] cfg_pwm [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
   int miscompares = 0;
   int checked = 0;
   always #2.5 pclk = ~pclk;
   byte_slave_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .data_pins_in(pins_in), .data_pins_out(pins_out),
      .data_pins_oe(pins_oe), .strobe_pin_zero_n(rd_n), .strobe_pin_one_n(wr_n),
      .strobe_pin_two_n(cs_n), .irq(irq));
   ext_cpu_model u_cpu (.pclk(pclk), .data_pins_out(pins_out), .data_pins_oe(pins_oe),
      .data_pins_in(pins_in), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n));
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // values read right after an edge are the ones sampled at it
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), e, rdata);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(off_strobe_dir, 32'h07);
      rd(off_converter, 32'h00);
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", 32'h1, err);
      $display("test reset done");
      wr(off_converter, 32'h0A);
      wr(off_strobe_dir, 32'h17);
      wr(off_enables, 32'h07);
      u_cpu.write_byte(8'h5A, 4);
      repeat (8) @(posedge pclk);
      chk("irq", 32'h1, irq);
      rd(off_strobe_dir, 32'h97);
      rd(off_flags, 32'h01);
      rd(off_flags, 32'h00);
      chk("irq", 32'h0, irq);
      rd(off_pins, 32'h5A);
      rd(off_strobe_dir, 32'h17);
      u_cpu.write_byte(8'h11, 10);
      repeat (8) @(posedge pclk);
      u_cpu.write_byte(8'h22, 4);
      repeat (8) @(posedge pclk);
      rd(off_strobe_dir, 32'hB7);
      rd(off_flags, 32'h05);
      wr(off_strobe_dir, 32'h17);
      rd(off_pins, 32'h22);
      rd(off_strobe_dir, 32'h17);
      $display("test external write done");
      wr(off_pins, 32'hC3);
      rd(off_strobe_dir, 32'h57);
      u_cpu.read_begin();
      u_cpu.read_end(8, q);
      chk("read byte", 32'hC3, q);
      repeat (8) @(posedge pclk);
      chk("pins oe", 32'h0, pins_oe);
      rd(off_flags, 32'h02);
      rd(off_strobe_dir, 32'h17);
      u_cpu.read_begin();
      repeat (8) @(posedge pclk);
      chk("pins oe", 32'hFF, pins_oe);
      wr(off_pins, 32'h3C);
      rd(off_strobe_dir, 32'h57);
      u_cpu.read_end(2, q);
      chk("read byte", 32'h3C, q);
      repeat (8) @(posedge pclk);
      rd(off_flags, 32'h02);
      $display("test external read done");
      for (int i = 0; i < 4; i++) begin
         wr(off_strobe_dir, cfg_dir[i]);
         wr(off_converter, cfg_conv[i]);
         wr(off_pwm_mode, cfg_pwm[i]);
         u_cpu.write_byte(8'h77, 6);
         repeat (8) @(posedge pclk);
         rd(off_flags, 32'h00);
      end
      $display("test disabled port done");
      summarize();
   end
endmodule // tb_byte_slave_port
